// >>> rtl/fmc_pkg.sv
// Package for the floppy misc command decoder: opcodes, layouts, byte counts.
// Assumes byte-wide command and result streams driven by a FIFO front end.
package fmc_pkg;
  // Opcodes in bits 4:0 (upper bits carry flags)
  localparam logic [4:0] OP_DUMP    = 5'h0E;
  localparam logic [4:0] OP_READ_ID = 5'h0A;
  localparam logic [4:0] OP_PERP    = 5'h12;
  localparam logic [4:0] OP_LOCK    = 5'h14;
  localparam logic [4:0] OP_READ    = 5'h06;
  localparam logic [4:0] OP_READ_DEL = 5'h0C;
  localparam logic [4:0] OP_WRITE   = 5'h05;
  localparam logic [4:0] OP_WRITE_DEL = 5'h09;
  localparam logic [4:0] OP_VERIFY  = 5'h16;
  localparam logic [4:0] OP_FORMAT  = 5'h0D;
  localparam logic [7:0] ST0_INVALID = 8'h80;
  localparam logic [3:0] DUMP_LEN   = 4'hA;
  localparam logic [3:0] XFER_PARAMS = 4'h8;
  localparam logic [3:0] XFER_RESULTS = 4'h7;
  localparam logic [3:0] RID_RESULTS = 4'h7;
  localparam int unsigned LOCK_BIT  = 7;
  localparam int unsigned LOCK_RES_BIT = 4;

  // Drive settings held elsewhere, reported by dump
  typedef struct packed {
    logic [3:0][7:0] present_cylinder_number;
    logic [3:0] step_rate_time;
    logic [3:0] head_unload_time;
    logic [6:0] head_load_time;
    logic       non_dma_flag;
    logic [7:0] sector_count;
    logic [7:0] end_of_track_sector;
    logic       implied_seek_enable;
    logic       fifo_disable_flag;
    logic       poll_disable;
    logic [3:0] fifo_threshold;
    logic [7:0] precomp_start_track;
  } fmc_cfg_s;

  // Engine status returned from the read/write engines
  typedef struct packed {
    logic [7:0] status_zero;
    logic [7:0] status_one;
    logic [7:0] status_two;
    logic [7:0] cyl;
    logic [7:0] head;
    logic [7:0] rec;
    logic [7:0] size;
  } fmc_res_s;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PARAM, ST_SEEK, ST_EXEC, ST_RESULT
  } fmc_state_e;
endpackage

// >>> rtl/fmc_decoder.sv
// Command decoder for dump, read id, perpendicular, lock, invalid and data transfer.
// Assumes cmd bytes arrive as one-cycle strobes and results are popped one per strobe.
// Notes on behaviour
// - Dump reports sector count after a format and end-of-track after a read or write.
// - Internal drive bits from perpendicular mode never reach drive select pins.
// - Read, write and verify share parameters and results, differing only in bits 0 to 4.
// - With implied seek enabled a data transfer seeks to the cylinder first.
// - The implied seek needs no extra bytes or host action.
// - The addressed drive's busy flag is set during the implied seek.
// - A failed implied seek is reported through the normal result phase.
// - On a failed seek status zero holds the error and the cylinder byte the failing cylinder.
// - Unknown opcodes go to standby and return one byte status zero of 80H.
// - Read id captures the first good id and returns three status then C, H, R, N.
`timescale 1ns/1ns
module fmc_decoder
(
  input  wire logic              clock_i,
  input  wire logic              srst_i,
  input  wire logic              cmd_valid_i,
  input  wire logic [7:0]        cmd_byte_i,
  input  wire logic              res_pop_i,
  input  wire fmc_pkg::fmc_cfg_s cfg_i,
  input  wire logic              seek_done_i,
  input  wire logic              seek_fail_i,
  input  wire logic [7:0]        seek_cyl_i,
  input  wire logic [7:0]        seek_st0_i,
  input  wire logic              exec_done_i,
  input  wire fmc_pkg::fmc_res_s exec_res_i,
  output logic                   res_valid_o,
  output logic [7:0]             res_byte_o,
  output logic                   busy_o,
  output logic [3:0]             drive_busy_o,
  output logic                   seek_start_o,
  output logic [7:0]             seek_cyl_o,
  output logic                   exec_start_o,
  output logic [4:0]             exec_op_o,
  output logic [1:0]             exec_drive_o,
  output logic                   exec_head_o,
  output logic                   lock_o,
  output logic [3:0]             perp_drive_bits_o,
  output logic                   perp_gap_o,
  output logic                   perp_perpendicular_write_gate_o,
  output logic                   standby_o
);
  import fmc_pkg::*;

  typedef struct packed {
    fmc_state_e      state;
    logic [4:0]      op;
    logic [3:0]      cnt;
    logic [3:0]      nres;
    logic [9:0][7:0] res;
    logic [7:0][7:0] par;
    logic            last_fmt;
    logic            lock;
    logic [3:0]      dbits;
    logic            perpendicular_gap_select;
    logic            perpendicular_write_gate;
    logic            seek_start;
    logic            exec_start;
    logic [3:0]      dbusy;
    logic            standby;
    logic            rvalid;
    logic            busy;
  } fmc_st_s;

  fmc_st_s st_r;
  fmc_st_s st_nxt;

  // Bytes following the opcode byte for each command
  function automatic logic [3:0] param_len(input logic [4:0] op);
    if (op == OP_READ_ID)
      return 4'h1;
    else if (op == OP_PERP)
      return 4'h1;
    else if (is_xfer(op))
      return XFER_PARAMS;
    else
      return 4'h0;
  endfunction

  function automatic logic is_xfer(input logic [4:0] op);
    return (op == OP_READ) || (op == OP_READ_DEL) || (op == OP_WRITE) ||
           (op == OP_WRITE_DEL) || (op == OP_VERIFY);
  endfunction

  // One pass of next-state logic
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.seek_start = 1'b0;
    st_nxt.exec_start = 1'b0;
    case (st_r.state)
      ST_IDLE:
      begin
        if (cmd_valid_i)
        begin
          st_nxt.op = cmd_byte_i[4:0];
          st_nxt.cnt = 4'h0;
          st_nxt.standby = 1'b0;
          if (cmd_byte_i[4:0] == OP_DUMP)
          begin
            st_nxt.res[0] = cfg_i.present_cylinder_number[0];
            st_nxt.res[1] = cfg_i.present_cylinder_number[1];
            st_nxt.res[2] = cfg_i.present_cylinder_number[2];
            st_nxt.res[3] = cfg_i.present_cylinder_number[3];
            st_nxt.res[4] = {cfg_i.step_rate_time, cfg_i.head_unload_time};
            st_nxt.res[5] = {cfg_i.head_load_time, cfg_i.non_dma_flag};
            st_nxt.res[6] = st_r.last_fmt ? cfg_i.sector_count : cfg_i.end_of_track_sector;
            st_nxt.res[7] = {st_r.lock, 1'b0, st_r.dbits, st_r.perpendicular_gap_select, st_r.perpendicular_write_gate};
            st_nxt.res[8] = {1'b0, cfg_i.implied_seek_enable, cfg_i.fifo_disable_flag,
                             cfg_i.poll_disable, cfg_i.fifo_threshold};
            st_nxt.res[9] = cfg_i.precomp_start_track;
            st_nxt.nres = DUMP_LEN;
            st_nxt.state = ST_RESULT;
          end
          else if (cmd_byte_i[4:0] == OP_LOCK)
          begin
            // lock from bit 7 echoed in bit 4
            st_nxt.lock = cmd_byte_i[LOCK_BIT];
            st_nxt.res[0] = '0;
            st_nxt.res[0][LOCK_RES_BIT] = cmd_byte_i[LOCK_BIT];
            st_nxt.nres = 4'h1;
            st_nxt.state = ST_RESULT;
          end
          else if (param_len(cmd_byte_i[4:0]) != 4'h0)
            st_nxt.state = ST_PARAM;
          else if (cmd_byte_i[4:0] == OP_FORMAT)
            st_nxt.last_fmt = 1'b1; // Format engine handled elsewhere
          else
          begin
            st_nxt.standby = 1'b1;
            st_nxt.res[0] = ST0_INVALID;
            st_nxt.nres = 4'h1;
            st_nxt.state = ST_RESULT;
          end
        end
      end
      ST_PARAM:
      begin
        if (cmd_valid_i)
        begin
          // perpendicular byte kept out of drive fields
          if (st_r.op != OP_PERP)
            st_nxt.par[st_r.cnt[2:0]] = cmd_byte_i;
          st_nxt.cnt = st_r.cnt + 4'h1;
          if (st_r.cnt + 4'h1 == param_len(st_r.op))
          begin
            if (st_r.op == OP_PERP)
            begin
              // drive bits kept internal, overwrite gated by bit 7
              if (cmd_byte_i[7])
                st_nxt.dbits = cmd_byte_i[5:2];
              st_nxt.perpendicular_gap_select = cmd_byte_i[1];
              st_nxt.perpendicular_write_gate = cmd_byte_i[0];
              st_nxt.state = ST_IDLE;
            end
            else if (is_xfer(st_r.op) && cfg_i.implied_seek_enable)
            begin
              // seek launched with no host action
              st_nxt.last_fmt = 1'b0;
              st_nxt.seek_start = 1'b1;
              st_nxt.dbusy = 4'h1 << st_r.par[0][1:0];
              st_nxt.state = ST_SEEK;
            end
            else
            begin
              if (is_xfer(st_r.op))
                st_nxt.last_fmt = 1'b0;
              st_nxt.exec_start = 1'b1;
              st_nxt.state = ST_EXEC;
            end
          end
        end
      end
      ST_SEEK:
      begin
        if (seek_fail_i)
        begin
          st_nxt.res[0] = seek_st0_i;
          st_nxt.res[1] = 8'h00;
          st_nxt.res[2] = 8'h00;
          st_nxt.res[3] = seek_cyl_i;
          st_nxt.res[4] = st_r.par[2];
          st_nxt.res[5] = st_r.par[3];
          st_nxt.res[6] = st_r.par[4];
          st_nxt.nres = XFER_RESULTS;
          st_nxt.dbusy = 4'h0;
          st_nxt.state = ST_RESULT;
        end
        else if (seek_done_i)
        begin
          st_nxt.dbusy = 4'h0;
          st_nxt.exec_start = 1'b1;
          st_nxt.state = ST_EXEC;
        end
      end
      ST_EXEC:
      begin
        if (exec_done_i)
        begin
          // seven result bytes, status then id
          st_nxt.res[0] = exec_res_i.status_zero;
          st_nxt.res[1] = exec_res_i.status_one;
          st_nxt.res[2] = exec_res_i.status_two;
          st_nxt.res[3] = exec_res_i.cyl;
          st_nxt.res[4] = exec_res_i.head;
          st_nxt.res[5] = exec_res_i.rec;
          st_nxt.res[6] = exec_res_i.size;
          st_nxt.nres = (st_r.op == OP_READ_ID) ? RID_RESULTS : XFER_RESULTS;
          st_nxt.state = ST_RESULT;
        end
      end
      ST_RESULT:
      begin
        // Shift so the head byte is always slot zero
        if (res_pop_i)
        begin
          st_nxt.res = {8'h00, st_r.res[9:1]};
          st_nxt.nres = st_r.nres - 4'h1;
          if (st_r.nres == 4'h1)
            st_nxt.state = ST_IDLE;
        end
      end
      default:
        st_nxt.state = ST_IDLE;
    endcase
    // Status flags registered so the outputs leave straight from flops
    st_nxt.rvalid = (st_nxt.state == ST_RESULT);
    st_nxt.busy   = (st_nxt.state != ST_IDLE);
    if (srst_i)
    begin
      st_nxt = '0;
      st_nxt.state = ST_IDLE;
    end
  end

  // Single state register
  always_ff @(posedge clock_i)
  begin
    st_r <= st_nxt;
  end

  assign res_valid_o       = st_r.rvalid;
  assign res_byte_o        = st_r.res[0];
  assign busy_o            = st_r.busy;
  assign drive_busy_o      = st_r.dbusy;
  assign seek_start_o      = st_r.seek_start;
  assign seek_cyl_o        = st_r.par[1];
  assign exec_start_o      = st_r.exec_start;
  assign exec_op_o         = st_r.op;
  assign exec_drive_o      = st_r.par[0][1:0];
  assign exec_head_o       = st_r.par[0][2];
  assign lock_o            = st_r.lock;
  assign perp_drive_bits_o = st_r.dbits;
  assign perp_gap_o        = st_r.perpendicular_gap_select;
  assign perp_perpendicular_write_gate_o      = st_r.perpendicular_write_gate;
  assign standby_o         = st_r.standby;
endmodule

// >>> sim/fmc_engine_model.sv
// Engine model: answers seek and transfer starts.
// Assumes start pulses from the decoder.
`timescale 1ns/1ns
module fmc_engine_model
#(
  parameter logic [55:0] RES  = '0,
  parameter logic [7:0]  FCYL = '0,
  parameter logic [7:0]  FST0 = '0
)
(
  input  wire logic         clock_i,
  input  wire logic         seek_start_i,
  input  wire logic         exec_start_i,
  input  wire logic         fail_i,
  input  wire logic [3:0]   lat_i,
  output logic              seek_done_o,
  output logic              seek_fail_o,
  output logic [7:0]        seek_cyl_o,
  output logic [7:0]        seek_st0_o,
  output logic              exec_done_o,
  output fmc_pkg::fmc_res_s exec_res_o
);
  import fmc_pkg::*;
  logic [3:0] sk = 4'h0;
  logic [3:0] ex = 4'h0;
  // Data only valid in the answer cycle, inverted else
  assign seek_cyl_o = seek_fail_o ? FCYL : ~FCYL;
  assign seek_st0_o = seek_fail_o ? FST0 : ~FST0;
  assign exec_res_o = exec_done_o ? RES : ~RES;
  // Countdown per engine; lat_i sets prompt or slow
  always @(posedge clock_i)
  begin
    sk <= seek_start_i ? lat_i : (sk != 4'h0 ? sk - 4'h1 : sk);
    ex <= exec_start_i ? lat_i : (ex != 4'h0 ? ex - 4'h1 : ex);
    seek_done_o <= (sk == 4'h1) && !fail_i;
    seek_fail_o <= (sk == 4'h1) && fail_i;
    exec_done_o <= (ex == 4'h1);
  end
endmodule

// >>> sim/fmc_decoder_chk.sv
// Port checker for the command decoder.
// Assumes bind onto fmc_decoder; one clock, sync reset.
`timescale 1ns/1ns
module fmc_decoder_chk
(
  input wire logic              clock_i,
  input wire logic              srst_i,
  input wire logic              cmd_valid_i,
  input wire logic [7:0]        cmd_byte_i,
  input wire fmc_pkg::fmc_cfg_s cfg_i,
  input wire logic              seek_done_i,
  input wire logic              seek_fail_i,
  input wire logic [7:0]        seek_st0_i,
  input wire logic              exec_done_i,
  input wire fmc_pkg::fmc_res_s exec_res_i,
  input wire logic              res_valid_o,
  input wire logic [7:0]        res_byte_o,
  input wire logic              busy_o,
  input wire logic [3:0]        drive_busy_o,
  input wire logic              exec_start_o,
  input wire logic              seek_start_o,
  input wire logic [1:0]        exec_drive_o,
  input wire logic [3:0]        perp_drive_bits_o,
  input wire logic              standby_o
);
  import fmc_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // Opcode byte taken only from idle
  wire       go    = cmd_valid_i && !busy_o;
  wire       lk    = cmd_byte_i[7];
  wire [7:0] ex_st = exec_res_i.status_zero;
  wire       skb   = |drive_busy_o;
  property p_dump;
    go && cmd_byte_i[4:0] == OP_DUMP |=> res_valid_o && res_byte_o == cfg_i.present_cylinder_number[0];
  endproperty
  a_dump: assert property (p_dump) else $error("dump first byte wrong");
  property p_lock;
    go && cmd_byte_i[4:0] == OP_LOCK |=> res_valid_o && res_byte_o == {3'h0, $past(lk), 4'h0};
  endproperty
  a_lock: assert property (p_lock) else $error("lock echo wrong");
  property p_inv;
    $rose(standby_o) |-> res_valid_o && res_byte_o == ST0_INVALID;
  endproperty
  a_inv: assert property (p_inv) else $error("invalid result wrong");
  property p_pins;
    $changed(perp_drive_bits_o) |-> $stable(exec_drive_o);
  endproperty
  a_pins: assert property (p_pins) else $error("perp bits reached drive");
  property p_busy;
    seek_start_o |-> $onehot(drive_busy_o) && busy_o;
  endproperty
  a_busy: assert property (p_busy) else $error("no drive busy in seek");
  property p_go;
    seek_done_i && skb |=> exec_start_o && drive_busy_o == 4'h0;
  endproperty
  a_go: assert property (p_go) else $error("no transfer after seek");
  property p_fail;
    seek_fail_i && skb |=> res_valid_o && res_byte_o == $past(seek_st0_i);
  endproperty
  a_fail: assert property (p_fail) else $error("seek failure not reported");
  property p_xres;
    exec_done_i && busy_o && !res_valid_o && !skb |=> res_valid_o && res_byte_o == $past(ex_st);
  endproperty
  a_xres: assert property (p_xres) else $error("transfer status wrong");
  c_fail: cover property (seek_fail_i && skb);
  c_exec: cover property (exec_start_o);
  c_inv: cover property ($rose(standby_o));
endmodule
bind fmc_decoder fmc_decoder_chk i_fmc_decoder_chk (.clock_i(clock_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i),
  .cmd_byte_i(cmd_byte_i), .cfg_i(cfg_i), .seek_done_i(seek_done_i), .seek_fail_i(seek_fail_i),
  .seek_st0_i(seek_st0_i), .exec_done_i(exec_done_i), .exec_res_i(exec_res_i), .res_valid_o(res_valid_o),
  .res_byte_o(res_byte_o), .busy_o(busy_o), .drive_busy_o(drive_busy_o), .exec_start_o(exec_start_o),
  .seek_start_o(seek_start_o), .exec_drive_o(exec_drive_o), .perp_drive_bits_o(perp_drive_bits_o),
  .standby_o(standby_o));

// >>> sim/fmc_decoder_tb.sv
// Testbench for the command decoder with engine model.
// Assumes 125 MHz clock and fixed drive settings.
`timescale 1ns/1ns
module fmc_decoder_tb;
  import fmc_pkg::*;
  localparam logic [55:0] RES  = 56'h40_00_00_21_01_06_02;
  localparam logic [7:0]  FCYL = 8'h1C;
  localparam logic [7:0]  FST0 = 8'h72;
  localparam logic [23:0] INV_OPS = 24'h001FE1;
  localparam logic [24:0] XFER_OPS = {OP_READ_DEL, OP_WRITE, OP_WRITE_DEL, OP_VERIFY, OP_READ};
  logic       clock_i = 1'b0;
  logic       srst_i = 1'b1;
  logic       cmd_valid_i = 1'b0;
  logic [7:0] cmd_byte_i = 8'h00;
  logic       res_pop_i = 1'b0;
  logic       fail = 1'b0;
  logic [3:0] lat = 4'h1;
  fmc_cfg_s   cfg_i;
  fmc_res_s   eres;
  logic       sd, sf, ed, rv, bz, ss, es, lko, sb, pgap, pwg, ehd;
  logic [4:0] eop;
  logic [7:0] scyl, sst0, rb, sco, seen_cyl, seen_exe;
  logic [3:0] db, pdb, seen_busy;
  logic [1:0] edr;
  logic [7:0] p [8];
  logic       lk = 1'b0;
  logic [5:0] pb = 6'h00;
  int         num_errors = 0;
  int         comparisons = 0;
  always #4 clock_i = ~clock_i;
  fmc_decoder i_fmc_decoder (.clock_i(clock_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i), .cmd_byte_i(cmd_byte_i),
    .res_pop_i(res_pop_i), .cfg_i(cfg_i), .seek_done_i(sd), .seek_fail_i(sf), .seek_cyl_i(scyl), .seek_st0_i(sst0),
    .exec_done_i(ed), .exec_res_i(eres), .res_valid_o(rv), .res_byte_o(rb), .busy_o(bz), .drive_busy_o(db),
    .seek_start_o(ss), .seek_cyl_o(sco), .exec_start_o(es), .exec_op_o(eop), .exec_drive_o(edr), .exec_head_o(ehd),
    .lock_o(lko), .perp_drive_bits_o(pdb), .perp_gap_o(pgap), .perp_perpendicular_write_gate_o(pwg), .standby_o(sb));
  fmc_engine_model #(.RES(RES), .FCYL(FCYL), .FST0(FST0)) i_fmc_engine_model (.clock_i(clock_i),
    .seek_start_i(ss), .exec_start_i(es), .fail_i(fail), .lat_i(lat), .seek_done_o(sd), .seek_fail_o(sf),
    .seek_cyl_o(scyl), .seek_st0_o(sst0), .exec_done_o(ed), .exec_res_o(eres));
  // Capture busy, seek cylinder and launched command; each opcode clears them
  always @(posedge clock_i)
  begin
    if (cmd_valid_i && !bz)
    begin
      seen_busy <= 4'h0;
      seen_cyl <= 8'h00;
      seen_exe <= 8'h00;
    end
    else
    begin
      if (|db)
        seen_busy <= db;
      if (ss)
        seen_cyl <= sco;
      if (es)
        seen_exe <= {eop, ehd, edr};
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e)
    begin
      num_errors++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic send(input logic [7:0] b);
    @(posedge clock_i);
    cmd_valid_i <= 1'b1;
    cmd_byte_i <= b;
    @(posedge clock_i);
    cmd_valid_i <= 1'b0;
  endtask
  // Bounded wait, then compare and pop one result
  task automatic getb(input string n, input logic [7:0] e);
    int k;
    k = 0;
    @(negedge clock_i);
    while (rv !== 1'b1 && k < 60)
    begin
      @(negedge clock_i);
      k++;
    end
    chk(n, e, rv === 1'b1 ? rb : ~e);
    @(posedge clock_i);
    res_pop_i <= 1'b1;
    @(posedge clock_i);
    res_pop_i <= 1'b0;
  endtask
  task automatic dump(input logic [7:0] s);
    logic [79:0] e;
    e = {32'h10111213, 8'hA5, 8'h57, s, lk, 1'b0, pb, 8'h57, 8'h40};
    send({3'h0, OP_DUMP});
    for (int i = 0; i < 10; i++) getb("dump", e[79-8*i -: 8]);
  endtask
  // Nine bytes only; any seek is hidden from the host
  task automatic xfer(input logic [7:0] op, input logic f);
    logic [55:0] e;
    e = f ? {FST0, 16'h0000, FCYL, p[2], p[3], p[4]} : RES;
    fail <= f;
    send(op);
    foreach (p[i]) send(p[i]);
    for (int i = 0; i < 7; i++) getb("xfer", e[55-8*i -: 8]);
    chk("drive busy", 8'h04, {4'h0, seen_busy});
    chk("seek cyl", p[1], seen_cyl);
    chk("exec cmd", f ? 8'h00 : {op[4:0], p[0][2:0]}, seen_exe);
  endtask
  task automatic summarize;
    $display("num_errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog well past the expected run
  initial
  begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    summarize;
  end
  initial
  begin
    cfg_i = {32'h13121110, 8'hA5, 7'h2B, 1'b1, 8'h09, 8'h12, 3'b101, 4'h7, 8'h40};
    p = '{8'h02, 8'h21, 8'h01, 8'h05, 8'h02, 8'h12, 8'h1B, 8'hFF};
    repeat (20) @(posedge clock_i);
    srst_i <= 1'b0;
    send({3'h0, OP_FORMAT});
    repeat (4) @(posedge clock_i);
    dump(8'h09);
    send(8'h14);
    getb("lock", 8'h00);
    chk("lock level", 8'h00, {7'h0, lko});
    send(8'h94);
    getb("lock", 8'h10);
    chk("lock level", 8'h01, {7'h0, lko});
    lk = 1'b1;
    send({3'h0, OP_PERP});
    send(8'hBD);
    pb = 6'h3D;
    repeat (2) @(posedge clock_i);
    chk("perp bits", 8'h0F, {4'h0, pdb});
    chk("drive pins", 8'h00, {6'h0, edr});
    chk("perp gap perpendicular_write_gate", 8'h01, {6'h0, pgap, pwg});
    chk("busy idle", 8'h00, {7'h0, bz});
    for (int i = 0; i < 3; i++)
    begin
      send(INV_OPS[23-8*i -: 8]);
      getb("invalid", ST0_INVALID);
      chk("standby", 8'h01, {7'h0, sb});
    end
    xfer({3'h2, OP_READ}, 1'b1);
    for (int i = 0; i < 5; i++)
    begin
      lat <= i[0] ? 4'h9 : 4'h1;
      xfer({3'h6, XFER_OPS[24-5*i -: 5]}, 1'b0);
    end
    dump(8'h12);
    send({3'h2, OP_READ_ID});
    send(8'h02);
    for (int i = 0; i < 7; i++) getb("read id", RES[55-8*i -: 8]);
    chk("exec cmd", {OP_READ_ID, 3'b010}, seen_exe);
    summarize;
  end
endmodule
